// file: timer_two_pkg.sv
// shared constants and types for the timer two baud / clock-out block
package timer_two_pkg;

    // register indices on the plain register port
    localparam logic [3:0] ADDR_CONTROL   = 4'h0;
    localparam logic [3:0] ADDR_MODE      = 4'h1;
    localparam logic [3:0] ADDR_RELOAD_LO = 4'h2;
    localparam logic [3:0] ADDR_RELOAD_HI = 4'h3;
    localparam logic [3:0] ADDR_COUNT_LO  = 4'h4;
    localparam logic [3:0] ADDR_COUNT_HI  = 4'h5;
    localparam logic [3:0] ADDR_IRQ_MASK  = 4'h6;
    localparam logic [3:0] ADDR_IRQ_SRC   = 4'h7;

    // control register fields
    localparam int CTL_OVF_BIT    = 7;
    localparam int CTL_EXT_BIT    = 6;
    localparam int CTL_RXSEL_BIT  = 5;
    localparam int CTL_TXSEL_BIT  = 4;
    localparam int CTL_EXTEN_BIT  = 3;
    localparam int CTL_RUN_BIT    = 2;
    localparam int CTL_CT_BIT     = 1;

    // mode register fields
    localparam int MODE_OE_BIT    = 1;

    // interrupt enable mask fields
    localparam int IE_GLOBAL_BIT  = 7;
    localparam int IE_RSVD_BIT    = 6;
    localparam int IE_T2_BIT      = 5;
    localparam int IE_SER_BIT     = 4;
    localparam int IE_T1_BIT      = 3;
    localparam int IE_X1_BIT      = 2;
    localparam int IE_T0_BIT      = 1;
    localparam int IE_X0_BIT      = 0;

    // reset values
    localparam logic [7:0] CONTROL_RESET  = 8'h00;
    localparam logic [7:0] MODE_RESET     = 8'h00;
    localparam logic [7:0] IRQ_MASK_RESET = 8'h00;
    localparam logic [7:0] RELOAD_RESET   = 8'h00;
    localparam logic [7:0] COUNT_RESET    = 8'h00;

    // timing: oscillator periods per state time and per machine cycle
    localparam int OSC_PER_STATE   = 2;
    localparam int OSC_PER_MACHINE = 12;

    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } reg_req_t;

    // six interrupt sources in mask bit order (bit 5 .. bit 0)
    typedef struct packed {
        logic timer_two;
        logic serial;
        logic timer_one;
        logic ext_one;
        logic timer_zero;
        logic ext_zero;
    } irq_src_t;

endpackage : timer_two_pkg

// file: pin_sync.sv
// three-stage synchroniser with agreement check for asynchronous pins
module pin_sync #(
    parameter int WIDTH = 2
) (
    input  wire logic             clock_i,
    input  wire logic             nrst_i,
    input  wire logic             ce_i,
    input  wire logic [WIDTH-1:0] async_i,
    input  wire logic [WIDTH-1:0] reset_level_i,
    output logic      [WIDTH-1:0] level_o
);
    logic [WIDTH-1:0] s1_q;
    logic [WIDTH-1:0] s2_q;
    logic [WIDTH-1:0] s3_q;
    logic [WIDTH-1:0] lvl_q;
    logic             init_q;

    initial begin
        if (WIDTH < 1) $error("pin_sync width must be at least one");
    end

    // first stage is read only by the second
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            // both pins idle high, so starting the stages there avoids a false fall
            s1_q <= '1;
            s2_q <= '1;
            s3_q <= '1;
        end else if (ce_i) begin
            s1_q <= async_i;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // a change counts only once stages two and three agree
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            lvl_q  <= '1;
            init_q <= 1'b0;
        end else if (ce_i) begin
            init_q <= 1'b1;
            for (int i = 0; i < WIDTH; i++) begin
                if (!init_q)
                    lvl_q[i] <= reset_level_i[i];
                else if (s2_q[i] == s3_q[i])
                    lvl_q[i] <= s3_q[i];
            end
        end
    end

    assign level_o = lvl_q;
endmodule : pin_sync

// file: timer_two_baud.sv
// timer two: baud generation, clock-out and interrupt enable mask
// Function
// - either clock-select bit set puts timer two into baud-generation mode
// - receive and transmit baud sources are selected independently
// - baud mode reloads the 16-bit count from reload pair on rollover
// - baud-mode timer increments once per state time, oscillator over two
// - ordinary timer increments once per machine cycle, oscillator over twelve
// - serial modes 1,3 baud equals oscillator over 32 times (65536 - reload)
// - baud-mode rollover sets no overflow flag and raises no interrupt
// - baud mode: trigger falling edge sets external flag, no reload
// - clock-out needs counter select clear, output enable set; run gates it
// - clock-out is 50% duty, oscillator over 4 times (65536 - reload)
// - clock-out rollovers generate no interrupt
// - baud and clock-out run together from one shared reload pair
// - shared pin also serves as the external count input
// - mask holds one enable bit per source at bits 5 to 0
// - global enable bit 7 clear blocks every pending output; the timer two request output is not gated by it
// - timer two request is overflow flag OR external flag
// - hardware never clears timer two flags on vectoring; software does
// - timer zero/one flags set late in cycle, polled in next cycle
// - counter mode counts input falling edges sampled once per machine cycle
module timer_two_baud
    import timer_two_pkg::*;
#(
    parameter int OSC_PER_CLK = 1
) (
    input  wire logic                    clock_i,
    input  wire logic                    nrst_i,
    input  wire logic                    ce_i,
    input  wire timer_two_pkg::reg_req_t req_i,
    output logic                   [7:0] rdata_o,
    input  wire logic                    shared_clock_pin_i,
    output logic                         shared_clock_pin_o,
    output logic                         shared_clock_pin_oe_n_o,
    input  wire logic                    external_trigger_input_i,
    input  wire logic                    timer_zero_overflow_flag_i,
    input  wire logic                    timer_one_overflow_flag_i,
    input  wire logic                    serial_irq_i,
    input  wire logic                    ext_zero_irq_i,
    input  wire logic                    ext_one_irq_i,
    output logic                         rx_baud_tick_o,
    output logic                         tx_baud_tick_o,
    output logic                         rx_use_timer_two_o,
    output logic                         tx_use_timer_two_o,
    output timer_two_pkg::irq_src_t      irq_pending_o,
    output logic                         timer_two_irq_request_o
);
    import timer_two_pkg::*;

    // one clock_i period stands for OSC_PER_CLK oscillator periods
    localparam int STATE_CLKS   = OSC_PER_STATE / OSC_PER_CLK;
    localparam int MACHINE_CLKS = OSC_PER_MACHINE / OSC_PER_CLK;

    initial begin
        if (OSC_PER_CLK != 1 && OSC_PER_CLK != 2)
            $error("OSC_PER_CLK must be 1 or 2");
    end

    // control and mode bits
    logic [7:0]  control_q;
    logic [7:0]  mode_q;
    logic [7:0]  irq_mask_q;
    logic [15:0] reload_q;
    logic [15:0] count_q;
    logic        clk_out_q;
    logic [3:0]  prescale_q;
    logic        trig_prev_q;
    logic        cnt_prev_q;
    logic [3:0]  tx_div_q;
    logic [3:0]  rx_div_q;
    logic [7:0]  rdata_q;

    logic        ovf_flag;
    logic        ext_flag;
    logic        rx_sel;
    logic        tx_sel;
    logic        ext_en;
    logic        run;
    logic        ct_sel;
    logic        clk_out_en;
    logic        baud_mode;
    logic        clk_out_mode;

    assign ovf_flag     = control_q[CTL_OVF_BIT];
    assign ext_flag     = control_q[CTL_EXT_BIT];
    assign rx_sel       = control_q[CTL_RXSEL_BIT];
    assign tx_sel       = control_q[CTL_TXSEL_BIT];
    assign ext_en       = control_q[CTL_EXTEN_BIT];
    assign run          = control_q[CTL_RUN_BIT];
    assign ct_sel       = control_q[CTL_CT_BIT];
    assign clk_out_en   = mode_q[MODE_OE_BIT];
    assign baud_mode    = rx_sel | tx_sel;
    assign clk_out_mode = clk_out_en & ~ct_sel;

    // synchronised pins
    logic [1:0] pin_lvl;
    pin_sync #(
        .WIDTH (2)
    ) u_sync (
        .clock_i       (clock_i),
        .nrst_i        (nrst_i),
        .ce_i          (ce_i),
        .async_i       ({external_trigger_input_i, shared_clock_pin_i}),
        .reset_level_i (2'b11),
        .level_o       (pin_lvl)
    );
    logic trig_lvl;
    logic cnt_lvl;
    assign trig_lvl = pin_lvl[1];
    assign cnt_lvl  = pin_lvl[0];

    // prescaler giving state-time and machine-cycle ticks
    logic state_tick;
    logic machine_tick;
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i)
            prescale_q <= 4'h0;
        else if (ce_i)
            prescale_q <= (prescale_q == 4'(MACHINE_CLKS - 1)) ? 4'h0 : prescale_q + 4'h1;
    end
    assign machine_tick = (prescale_q == 4'(MACHINE_CLKS - 1));
    assign state_tick   = (STATE_CLKS == 1) ? 1'b1
                        : (prescale_q[0] == 1'b1);

    // edge sampling once per machine cycle
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            trig_prev_q <= 1'b1;
            cnt_prev_q  <= 1'b1;
        end else if (ce_i && machine_tick) begin
            trig_prev_q <= trig_lvl;
            cnt_prev_q  <= cnt_lvl;
        end
    end
    logic trig_fall;
    logic cnt_fall;
    assign trig_fall = machine_tick & trig_prev_q & ~trig_lvl;
    assign cnt_fall  = machine_tick & cnt_prev_q & ~cnt_lvl;

    // increment source: counter edges, or state time in baud/clock-out, else machine cycle
    logic inc;
    always_comb begin
        if (!run)
            inc = 1'b0;
        else if (ct_sel)
            inc = cnt_fall;
        else if (baud_mode || clk_out_mode)
            inc = state_tick;
        else
            inc = machine_tick;
    end

    logic rollover;
    logic reload_on_ext;
    assign rollover      = inc & (count_q == 16'hffff);
    assign reload_on_ext = ext_en & trig_fall & ~baud_mode;

    // register write decode
    function automatic logic wr_hit(input reg_req_t r, input logic [3:0] a);
        return r.wr && (r.addr == a);
    endfunction

    // counter: reload on rollover from the shared pair
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i)
            count_q <= {COUNT_RESET, COUNT_RESET};
        else if (ce_i) begin
            if (wr_hit(req_i, ADDR_COUNT_LO))
                count_q[7:0] <= req_i.wdata;
            else if (wr_hit(req_i, ADDR_COUNT_HI))
                count_q[15:8] <= req_i.wdata;
            else if (rollover || reload_on_ext)
                count_q <= reload_q;
            else if (inc)
                count_q <= count_q + 16'h0001;
        end
    end

    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i)
            reload_q <= {RELOAD_RESET, RELOAD_RESET};
        else if (ce_i) begin
            if (wr_hit(req_i, ADDR_RELOAD_LO))
                reload_q[7:0] <= req_i.wdata;
            else if (wr_hit(req_i, ADDR_RELOAD_HI))
                reload_q[15:8] <= req_i.wdata;
        end
    end

    // control register; hardware sets win over software clears
    logic set_ovf;
    logic set_ext;
    assign set_ovf = rollover & ~baud_mode & ~clk_out_mode;
    assign set_ext = ext_en & trig_fall;
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i)
            control_q <= CONTROL_RESET;
        else if (ce_i) begin
            if (wr_hit(req_i, ADDR_CONTROL))
                control_q <= req_i.wdata;
            if (set_ovf)
                control_q[CTL_OVF_BIT] <= 1'b1;
            if (set_ext)
                control_q[CTL_EXT_BIT] <= 1'b1;
        end
    end

    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i)
            mode_q <= MODE_RESET;
        else if (ce_i && wr_hit(req_i, ADDR_MODE))
            mode_q <= {6'h00, req_i.wdata[1:0]};
    end

    // reserved bit 6 is not stored, so stray ones read back as zero
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i)
            irq_mask_q <= IRQ_MASK_RESET;
        else if (ce_i && wr_hit(req_i, ADDR_IRQ_MASK)) begin
            irq_mask_q              <= req_i.wdata;
            irq_mask_q[IE_RSVD_BIT] <= 1'b0;
        end
    end

    // clock-out pin toggles on every rollover: half period = 65536 - reload state times
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i)
            clk_out_q <= 1'b0;
        else if (ce_i) begin
            if (!clk_out_mode)
                clk_out_q <= 1'b0;
            else if (rollover)
                clk_out_q <= ~clk_out_q;
        end
    end
    assign shared_clock_pin_o      = clk_out_q;
    assign shared_clock_pin_oe_n_o = ~clk_out_mode;

    // baud ticks: rollover divided by 16 gives osc/(32*(65536-reload)) per bit
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            tx_div_q <= 4'h0;
            rx_div_q <= 4'h0;
        end else if (ce_i) begin
            if (tx_sel && rollover)
                tx_div_q <= tx_div_q + 4'h1;
            if (rx_sel && rollover)
                rx_div_q <= rx_div_q + 4'h1;
        end
    end
    assign tx_baud_tick_o     = ce_i & tx_sel & rollover & (tx_div_q == 4'hf);
    assign rx_baud_tick_o     = ce_i & rx_sel & rollover & (rx_div_q == 4'hf);
    assign tx_use_timer_two_o = tx_sel;
    assign rx_use_timer_two_o = rx_sel;

    // interrupt gating; timer zero/one flags arrive already late-set from their timers
    irq_src_t src;
    always_comb begin
        src.timer_two  = ovf_flag | ext_flag;
        src.serial     = serial_irq_i;
        src.timer_one  = timer_one_overflow_flag_i;
        src.ext_one    = ext_one_irq_i;
        src.timer_zero = timer_zero_overflow_flag_i;
        src.ext_zero   = ext_zero_irq_i;
    end
    // combinational so the timer two flag is seen in its own cycle
    assign irq_pending_o = irq_mask_q[IE_GLOBAL_BIT]
                         ? (src & irq_mask_q[5:0]) : '0;
    assign timer_two_irq_request_o = src.timer_two;

    // read port, data one cycle after the strobe
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i)
            rdata_q <= 8'h00;
        else if (ce_i) begin
            if (req_i.rd) begin
                unique case (req_i.addr)
                    ADDR_CONTROL:   rdata_q <= control_q;
                    ADDR_MODE:      rdata_q <= mode_q;
                    ADDR_RELOAD_LO: rdata_q <= reload_q[7:0];
                    ADDR_RELOAD_HI: rdata_q <= reload_q[15:8];
                    ADDR_COUNT_LO:  rdata_q <= count_q[7:0];
                    ADDR_COUNT_HI:  rdata_q <= count_q[15:8];
                    ADDR_IRQ_MASK:  rdata_q <= irq_mask_q;
                    ADDR_IRQ_SRC:   rdata_q <= {2'b00, src};
                    default:        rdata_q <= 8'h00;
                endcase
            end else
                rdata_q <= 8'h00;
        end
    end
    assign rdata_o = rdata_q;
endmodule : timer_two_baud

// file: timer_two_baud_checker.sv
// assertion checker for the timer two baud / clock-out block
module timer_two_baud_checker
    import timer_two_pkg::*;
#(
    parameter int OSC_PER_CLK = 1
) (
    input wire logic                    clock_i,
    input wire logic                    nrst_i,
    input wire logic                    ce_i,
    input wire timer_two_pkg::reg_req_t req_i,
    input wire logic              [7:0] rdata_o,
    input wire logic                    shared_clock_pin_i,
    input wire logic                    shared_clock_pin_o,
    input wire logic                    shared_clock_pin_oe_n_o,
    input wire logic                    external_trigger_input_i,
    input wire logic                    timer_zero_overflow_flag_i,
    input wire logic                    timer_one_overflow_flag_i,
    input wire logic                    serial_irq_i,
    input wire logic                    ext_zero_irq_i,
    input wire logic                    ext_one_irq_i,
    input wire logic                    rx_baud_tick_o,
    input wire logic                    tx_baud_tick_o,
    input wire logic                    rx_use_timer_two_o,
    input wire logic                    tx_use_timer_two_o,
    input wire timer_two_pkg::irq_src_t irq_pending_o,
    input wire logic                    timer_two_irq_request_o
);
    import timer_two_pkg::*;
    // last software-written values, flag bits included; hardware flag sets are never mirrored here
    logic [7:0] ctl_q;
    logic [7:0] mode_q;
    logic [7:0] mask_q;
    wire        wr_c   = ce_i && req_i.wr;
    wire        clkout = mode_q[MODE_OE_BIT] && !ctl_q[CTL_CT_BIT];
    wire        baud   = ctl_q[CTL_RXSEL_BIT] || ctl_q[CTL_TXSEL_BIT];

    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ctl_q  <= 8'h00;
            mode_q <= 8'h00;
            mask_q <= 8'h00;
        end else if (wr_c) begin
            if (req_i.addr == ADDR_CONTROL) ctl_q <= req_i.wdata;
            if (req_i.addr == ADDR_MODE) mode_q <= req_i.wdata;
            if (req_i.addr == ADDR_IRQ_MASK) mask_q <= req_i.wdata & 8'hbf;
        end
    end

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!nrst_i);

    sequence mask_read;
        ce_i && req_i.rd && req_i.addr == ADDR_IRQ_MASK;
    endsequence

    mask_read_back_a: assert property (mask_read |=> rdata_o == $past(mask_q))
        else $error("mask read back wrong");
    global_gate_a: assert property (!mask_q[7] |-> irq_pending_o == 6'h00)
        else $error("pending seen with global enable clear");
    source_enable_a: assert property (mask_q[7] |-> irq_pending_o[4:0] == (mask_q[4:0] &
        {serial_irq_i, timer_one_overflow_flag_i, ext_one_irq_i, timer_zero_overflow_flag_i,
         ext_zero_irq_i})) else $error("source pending not gated by its enable");
    t2_request_a: assert property (irq_pending_o.timer_two ==
        (mask_q[7] && mask_q[5] && timer_two_irq_request_o)) else $error("timer two pending wrong");
    select_follow_a: assert property (rx_use_timer_two_o == ctl_q[5] && tx_use_timer_two_o == ctl_q[4])
        else $error("baud source select wrong");
    tick_needs_select_a: assert property ((rx_baud_tick_o |-> ctl_q[5]) and (tx_baud_tick_o |-> ctl_q[4]))
        else $error("baud tick without its select");
    pin_enable_a: assert property (shared_clock_pin_oe_n_o == !clkout)
        else $error("clock pin enable wrong");
    pin_hold_a: assert property (!clkout && !$past(clkout) && !$past(clkout, 2) |->
        $stable(shared_clock_pin_o))
        else $error("clock pin moved outside clock-out");
    toggle_spacing_a: assert property (clkout && $changed(shared_clock_pin_o) |=>
        $stable(shared_clock_pin_o)) else $error("clock pin toggled twice in a row");
    no_rollover_irq_a: assert property ((baud || clkout) && !ctl_q[3] && !$past(wr_c) &&
        $past(baud || clkout) |-> !$rose(timer_two_irq_request_o)) else $error("rollover raised request");
endmodule : timer_two_baud_checker

bind timer_two_baud timer_two_baud_checker #(.OSC_PER_CLK(OSC_PER_CLK)) u_timer_two_baud_checker (
    .clock_i(clock_i), .nrst_i(nrst_i), .ce_i(ce_i), .req_i(req_i), .rdata_o(rdata_o),
    .shared_clock_pin_i(shared_clock_pin_i), .shared_clock_pin_o(shared_clock_pin_o),
    .shared_clock_pin_oe_n_o(shared_clock_pin_oe_n_o),
    .external_trigger_input_i(external_trigger_input_i),
    .timer_zero_overflow_flag_i(timer_zero_overflow_flag_i),
    .timer_one_overflow_flag_i(timer_one_overflow_flag_i), .serial_irq_i(serial_irq_i),
    .ext_zero_irq_i(ext_zero_irq_i), .ext_one_irq_i(ext_one_irq_i),
    .rx_baud_tick_o(rx_baud_tick_o), .tx_baud_tick_o(tx_baud_tick_o),
    .rx_use_timer_two_o(rx_use_timer_two_o), .tx_use_timer_two_o(tx_use_timer_two_o),
    .irq_pending_o(irq_pending_o), .timer_two_irq_request_o(timer_two_irq_request_o));

// file: serial_far_end.sv
// far-side model: serial port tick counters and the two pulled-up pins
module serial_far_end (
    input  wire logic        clock_i,
    input  wire logic        nrst_i,
    input  wire logic        pin_o_i,
    input  wire logic        pin_oe_n_i,
    input  wire logic        rx_tick_i,
    input  wire logic        tx_tick_i,
    input  wire logic        pin_low_i,
    input  wire logic        trig_low_i,
    output logic             pin_level_o,
    output logic             trig_level_o,
    output logic      [15:0] rx_ticks_o,
    output logic      [15:0] tx_ticks_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // pull-ups: a released line reads high, any low driver wins
    assign pin_level_o  = (pin_oe_n_i ? 1'b1 : pin_o_i) & !pin_low_i;
    assign trig_level_o = !trig_low_i;
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rx_ticks_o <= 16'h0000;
            tx_ticks_o <= 16'h0000;
        end else begin
            rx_ticks_o <= rx_ticks_o + {15'h0000, rx_tick_i};
            tx_ticks_o <= tx_ticks_o + {15'h0000, tx_tick_i};
        end
    end
endmodule : serial_far_end

// file: test_timer_two_baud.sv
// self-checking bench for the timer two baud / clock-out block
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin num_errors++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e); end end
module test_timer_two_baud
    import timer_two_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clock_i, nrst_i, pin_o, oe_n, pin_lvl, trig_lvl, pin_low, trig_low, t2req;
    logic        t0f, t1f, ser, x0, x1, rx_tick, tx_tick, rx_use, tx_use;
    logic [7:0]  rdata, m;
    logic [5:0]  s;
    logic [15:0] rx_n, tx_n;
    reg_req_t    req;
    irq_src_t    pend;
    int          num_errors = 0, num_checks = 0, seed = 32'hab52, n, i;
    time         t1;

    timer_two_baud #(.OSC_PER_CLK(1)) u_timer_two_baud (.clock_i(clock_i), .nrst_i(nrst_i),
        .ce_i(1'b1), .req_i(req), .rdata_o(rdata), .shared_clock_pin_i(pin_lvl),
        .shared_clock_pin_o(pin_o), .shared_clock_pin_oe_n_o(oe_n),
        .external_trigger_input_i(trig_lvl), .timer_zero_overflow_flag_i(t0f),
        .timer_one_overflow_flag_i(t1f), .serial_irq_i(ser), .ext_zero_irq_i(x0),
        .ext_one_irq_i(x1), .rx_baud_tick_o(rx_tick), .tx_baud_tick_o(tx_tick),
        .rx_use_timer_two_o(rx_use), .tx_use_timer_two_o(tx_use), .irq_pending_o(pend),
        .timer_two_irq_request_o(t2req));
    serial_far_end u_serial_far_end (.clock_i(clock_i), .nrst_i(nrst_i), .pin_o_i(pin_o),
        .pin_oe_n_i(oe_n), .rx_tick_i(rx_tick), .tx_tick_i(tx_tick), .pin_low_i(pin_low),
        .trig_low_i(trig_low), .pin_level_o(pin_lvl), .trig_level_o(trig_lvl),
        .rx_ticks_o(rx_n), .tx_ticks_o(tx_n));

    function automatic irq_src_t exp_irq(input logic [7:0] mk, input logic [5:0] sr);
        return mk[IE_GLOBAL_BIT] ? irq_src_t'(mk[5:0] & sr) : irq_src_t'(6'h00);
    endfunction : exp_irq

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clock_i);
        req <= '{a, d, 1'b1, 1'b0};
        @(posedge clock_i);
        req <= '{a, d, 1'b0, 1'b0};
        #1;
    endtask : wr

    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge clock_i);
        req <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge clock_i);
        req <= '{a, 8'h00, 1'b0, 1'b0};
        #1;
        `CHK(rdata, e)
    endtask : rd

    // cycles between two events: 0 pin change, 1 receive tick
    task automatic gap(input int w, output int g);
        int k, first;
        logic prev;
        first = -1;
        g = 0;
        prev = pin_o;
        for (k = 0; k < 4000 && g == 0; k++) begin
            @(posedge clock_i);
            #1;
            if (w == 0 ? pin_o !== prev : rx_tick === 1'b1) begin
                if (first >= 0) g = k - first;
                else first = k;
            end
            prev = pin_o;
        end
        if (g == 0) begin
            num_errors++;
            wrap_up();
        end
    endtask : gap

    task automatic wait_req();
        int k;
        for (k = 0; k < 400 && t2req !== 1'b1; k++) begin
            @(posedge clock_i);
            #1;
        end
        if (t2req !== 1'b1) begin
            num_errors++;
            wrap_up();
        end
    endtask : wait_req

    task automatic wrap_up();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : wrap_up

    initial begin
        clock_i = 1'b0;
        forever #10 clock_i = ~clock_i;
    end

    initial begin
        nrst_i = 1'b0;
        req = '0;
        {t0f, t1f, ser, x0, x1, pin_low, trig_low} = 7'h00;
        repeat (2) @(posedge clock_i);
        nrst_i <= 1'b1;
        for (i = 0; i < 9; i++) rd(i[3:0], 8'h00);
        wr(4'h9, 8'hff);
        rd(4'h9, 8'h00);
        $display("reset values done");
        for (i = 0; i < 24; i++) begin
            m = (i == 0) ? 8'h3f : (i == 1) ? 8'hbf : 8'($random(seed)) & 8'hbf;
            s = 6'($random(seed));
            @(posedge clock_i);
            {ser, t1f, x1, t0f, x0} <= s[4:0];
            wr(ADDR_IRQ_MASK, m);
            rd(ADDR_IRQ_MASK, m);
            `CHK(pend, exp_irq(m, {1'b0, s[4:0]}))
        end
        wr(ADDR_IRQ_MASK, 8'ha0);
        $display("interrupt mask done");
        wr(ADDR_RELOAD_LO, 8'hf0);
        wr(ADDR_RELOAD_HI, 8'hff);
        wr(ADDR_COUNT_LO, 8'hf0);
        wr(ADDR_COUNT_HI, 8'hff);
        wr(ADDR_MODE, 8'h02);
        wr(ADDR_CONTROL, 8'h04);
        `CHK(oe_n, 1'b0)
        gap(0, n);
        `CHK(n, 32)
        `CHK(t2req, 1'b0)
        $display("clock-out done");
        wr(ADDR_CONTROL, 8'h00);
        wr(ADDR_CONTROL, 8'h24);
        gap(1, n);
        `CHK(n, 512)
        gap(0, n);
        `CHK(n, 32)
        `CHK({rx_use, tx_use, tx_n}, {2'b10, 16'h0000})
        `CHK(rx_n != 16'h0000, 1'b1)
        `CHK(t2req, 1'b0)
        $display("baud generation done");
        wr(ADDR_CONTROL, 8'h3c);
        @(posedge clock_i);
        trig_low <= 1'b1;
        wait_req();
        `CHK(pend.timer_two, 1'b1)
        @(posedge clock_i);
        trig_low <= 1'b0;
        rd(ADDR_CONTROL, 8'h7c);
        wr(ADDR_CONTROL, 8'h3c);
        `CHK(t2req, 1'b0)
        $display("external flag done");
        wr(ADDR_CONTROL, 8'h00);
        wr(ADDR_MODE, 8'h00);
        wr(ADDR_COUNT_LO, 8'hf0);
        wr(ADDR_COUNT_HI, 8'hff);
        wr(ADDR_CONTROL, 8'h04);
        wait_req();
        t1 = $time;
        wr(ADDR_CONTROL, 8'h04);
        wait_req();
        `CHK(($time - t1) / 20, 64'd192)
        $display("normal timer done");
        wr(ADDR_CONTROL, 8'h00);
        wr(ADDR_COUNT_LO, 8'hff);
        wr(ADDR_COUNT_HI, 8'hff);
        wr(ADDR_CONTROL, 8'h06);
        `CHK(oe_n, 1'b1)
        @(posedge clock_i);
        pin_low <= 1'b1;
        wait_req();
        `CHK(t2req, 1'b1)
        $display("counter done");
        wrap_up();
    end
endmodule : test_timer_two_baud
